// file: verilog/tmrcnt_core.sv
// 8-bit timer counter: clock source select, count unit, normal and CLEAR_ON_COMPARE_MODE modes
`timescale 1ns/100ps
module tmrcnt_core import tmrcnt_pkg::*; #(
    parameter int unsigned PRESCALE_W = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire tmrcnt_pkg::tmrcnt_req_t req,
    output logic [7:0] rdata,
    // Oscillator pin, asynchronous to sys_clk
    input wire logic osc_pin_in,
    output logic osc_pin_out,
    // Interrupt acknowledges from the vector logic
    input wire logic ovf_ack,
    input wire logic cmpa_ack,
    input wire logic cmpb_ack,
    // Interrupt requests and compare outputs
    output logic ovf_irq,
    output logic cmpa_irq,
    output logic cmpb_irq,
    output tmrcnt_pkg::tmrcnt_cmp_out_t cmp_out
);
    import tmrcnt_pkg::*;

    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_b_r;
    logic [7:0] count_value_r;
    logic [7:0] count_value_nxt;
    logic [7:0] compare_a_value_r;
    logic [7:0] compare_b_value_r;
    logic overflow_flag_r;
    logic compare_a_flag_r;
    logic compare_b_flag_r;
    logic async_clock_select_r;
    logic [7:0] rdata_r;
    logic osc_meta_r;
    logic osc_sync_r;
    logic osc_prev_r;
    logic [PRESCALE_W-1:0] presc_r;
    logic timer_clock;
    logic src_tick;
    logic [2:0] clock_select_field;
    tmrcnt_wgm_t waveform_mode_field;
    logic count_wr;
    logic at_max;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic ovf_set;
    logic cmpa_set;
    logic cmpb_set;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic pwm_mode;
    logic cmp_a_r;
    logic cmp_b_r;
    logic [3:0] tick_gap_r;
    logic [2:0] gap_cs_r;
    logic gap_seen_r;

    function automatic logic wr_hit(input tmrcnt_req_t r, input logic [3:0] off);
        wr_hit = r.wr && (r.addr == off);
    endfunction : wr_hit

    function automatic logic edge_of(input logic now, input logic was);
        edge_of = now && !was;
    endfunction : edge_of

    // Tap bit k rises on this source tick when bits k..0 read zero then all ones
    function automatic logic tap_hit(input logic [PRESCALE_W-1:0] p, input int unsigned k);
        logic [PRESCALE_W-1:0] mask;
        mask = PRESCALE_W'((64'h2 << k) - 64'h1);
        tap_hit = (p & mask) == (mask >> 1);
    endfunction : tap_hit

    // Output pin level for a non-PWM match
    function automatic logic match_level(input logic [1:0] com, input logic cur);
        unique case (com)
            2'h0: match_level = cur;
            2'h1: match_level = !cur;
            2'h2: match_level = 1'b0;
            2'h3: match_level = 1'b1;
        endcase
    endfunction : match_level

    assign waveform_mode_field = tmrcnt_wgm_t'({ctrl_b_r[CTRLB_WGM2_POS], ctrl_a_r[CTRLA_WGM1_POS],
        ctrl_a_r[CTRLA_WGM0_POS]});
    assign clock_select_field = ctrl_b_r[CTRLB_CS_POS +: 3];
    assign com_a = ctrl_a_r[CTRLA_COMA_POS +: 2];
    assign com_b = ctrl_a_r[CTRLA_COMB_POS +: 2];
    assign count_wr = wr_hit(req, OFF_COUNT);
    assign at_max = (count_value_r == CNT_MAX);
    assign at_bottom = (count_value_r == CNT_BOTTOM);
    assign match_a = (count_value_r == compare_a_value_r);
    assign match_b = (count_value_r == compare_b_value_r);
    assign pwm_mode = (waveform_mode_field != TMRCNT_WGM_NORMAL) && (waveform_mode_field != TMRCNT_WGM_CTC);

    // Oscillator pin synchroniser; edges are taken from the second stage and its delayed copy
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_meta_r <= osc_pin_in;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end

    // Free-running prescaler on the selected source
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            presc_r <= '0;
        end else begin
            if (src_tick) begin
                presc_r <= presc_r + 1'b1;
            end
        end
    end

    // Source tick: every I/O cycle, or each rising oscillator edge
    assign src_tick = async_clock_select_r ? edge_of(osc_sync_r, osc_prev_r) : 1'b1;

    // Clock select: stop, direct, or prescaler bit rising
    // Taps fire with the source tick itself, so a slow oscillator still divides
    always_comb begin
        unique case (clock_select_field)
            3'h0: timer_clock = 1'b0;
            3'h1: timer_clock = src_tick;
            3'h2: timer_clock = src_tick && tap_hit(presc_r, 2);
            3'h3: timer_clock = src_tick && tap_hit(presc_r, 4);
            3'h4: timer_clock = src_tick && tap_hit(presc_r, 5);
            3'h5: timer_clock = src_tick && tap_hit(presc_r, 6);
            3'h6: timer_clock = src_tick && tap_hit(presc_r, 7);
            3'h7: timer_clock = src_tick && tap_hit(presc_r, PRESCALE_W-1);
        endcase
    end

    // Counter next value; compare output bits do not enter here
    always_comb begin
        count_value_nxt = count_value_r;
        if (count_wr) begin
            count_value_nxt = req.wdata;
        end else if (timer_clock) begin
            unique case (waveform_mode_field)
                TMRCNT_WGM_CTC: count_value_nxt = match_a ? CNT_BOTTOM : count_value_r + 8'h01;
                default: count_value_nxt = count_value_r + 8'h01;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_value_r <= RST_COUNT;
        end else begin
            count_value_r <= count_value_nxt;
        end
    end

    // Flag events; a match during a count write is suppressed
    assign ovf_set = timer_clock && !count_wr && at_max &&
        !((waveform_mode_field == TMRCNT_WGM_CTC) && match_a);
    assign cmpa_set = timer_clock && !count_wr && match_a;
    assign cmpb_set = timer_clock && !count_wr && match_b;

    // Set wins over clear on every flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overflow_flag_r <= 1'b0;
            compare_a_flag_r <= 1'b0;
            compare_b_flag_r <= 1'b0;
        end else begin
            overflow_flag_r <= ovf_set || (overflow_flag_r && !ovf_ack &&
                !(wr_hit(req, OFF_FLAGS) && req.wdata[FLAG_OVF_POS]));
            compare_a_flag_r <= cmpa_set || (compare_a_flag_r && !cmpa_ack &&
                !(wr_hit(req, OFF_FLAGS) && req.wdata[FLAG_CMPA_POS]));
            compare_b_flag_r <= cmpb_set || (compare_b_flag_r && !cmpb_ack &&
                !(wr_hit(req, OFF_FLAGS) && req.wdata[FLAG_CMPB_POS]));
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_a_r <= RST_CTRL;
            ctrl_b_r <= RST_CTRL;
            compare_a_value_r <= RST_CMP;
            compare_b_value_r <= RST_CMP;
            async_clock_select_r <= 1'b0;
        end else begin
            if (wr_hit(req, OFF_CTRL_A)) begin
                ctrl_a_r <= req.wdata;
            end
            if (wr_hit(req, OFF_CTRL_B)) begin
                ctrl_b_r <= {4'h0, req.wdata[3:0]};
            end
            if (wr_hit(req, OFF_CMP_A)) begin
                compare_a_value_r <= req.wdata;
            end
            if (wr_hit(req, OFF_CMP_B)) begin
                compare_b_value_r <= req.wdata;
            end
            if (wr_hit(req, OFF_ASYNC)) begin
                async_clock_select_r <= req.wdata[ASYNC_SEL_POS];
            end
        end
    end

    // Compare output pins, non-PWM set/clear/toggle; PWM modes leave them unchanged
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmp_a_r <= 1'b0;
            cmp_b_r <= 1'b0;
        end else begin
            if (cmpa_set && !pwm_mode) begin
                cmp_a_r <= match_level(com_a, cmp_a_r);
            end
            if (cmpb_set && !pwm_mode) begin
                cmp_b_r <= match_level(com_b, cmp_b_r);
            end
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (!req.rd) begin
            rdata_r <= 8'h00;
        end else begin
            unique case (req.addr)
                OFF_CTRL_A: rdata_r <= ctrl_a_r;
                OFF_CTRL_B: rdata_r <= ctrl_b_r;
                OFF_COUNT: rdata_r <= count_value_r;
                OFF_CMP_A: rdata_r <= compare_a_value_r;
                OFF_CMP_B: rdata_r <= compare_b_value_r;
                OFF_FLAGS: rdata_r <= {5'h00, compare_b_flag_r, compare_a_flag_r, overflow_flag_r};
                OFF_ASYNC: rdata_r <= {2'h0, async_clock_select_r, 5'h00};
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign rdata = rdata_r;
    assign ovf_irq = overflow_flag_r;
    assign cmpa_irq = compare_a_flag_r;
    assign cmpb_irq = compare_b_flag_r;
    assign cmp_out.cmp_a = cmp_a_r;
    assign cmp_out.cmp_b = cmp_b_r;
    // Crystal drive is analog; the digital model holds it low
    assign osc_pin_out = 1'b0;

    // Checker helper: cycles between ticks on the divide-by-eight tap
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gap_cs_r <= 3'h0;
            gap_seen_r <= 1'b0;
            tick_gap_r <= 4'h0;
        end else begin
            gap_cs_r <= clock_select_field;
            if (clock_select_field != gap_cs_r || async_clock_select_r) begin
                gap_seen_r <= 1'b0;
                tick_gap_r <= 4'h0;
            end else if (timer_clock) begin
                gap_seen_r <= 1'b1;
                tick_gap_r <= 4'h0;
            end else if (tick_gap_r != 4'hf) begin
                tick_gap_r <= tick_gap_r + 4'h1;
            end
        end
    end
    a_div8_gap: assert property (@(posedge sys_clk) disable iff (rst)
        clock_select_field == 3'h2 && !async_clock_select_r && gap_seen_r && timer_clock
        |-> tick_gap_r == 4'h7)
        else $error("Divide-by-eight tap ticked off period");

    a_stop_holds: assert property (@(posedge sys_clk) disable iff (rst)
        (clock_select_field == CS_STOPPED) && !count_wr |=> $stable(count_value_r))
        else $error("Counter moved while clock select is zero");
    a_write_wins: assert property (@(posedge sys_clk) disable iff (rst)
        count_wr |=> count_value_r == $past(req.wdata))
        else $error("Count write did not take priority");
    a_normal_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && waveform_mode_field == TMRCNT_WGM_NORMAL && at_max |=> at_bottom)
        else $error("Normal mode did not wrap to zero");
    a_normal_incr: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && waveform_mode_field == TMRCNT_WGM_NORMAL
        |=> count_value_r == $past(count_value_r) + 8'h01)
        else $error("Normal mode did not increment");
    a_ovf_zero: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && waveform_mode_field == TMRCNT_WGM_NORMAL && at_max
        |=> overflow_flag_r && at_bottom)
        else $error("Overflow flag missing at zero");
    a_ctc_clear: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && waveform_mode_field == TMRCNT_WGM_CTC && match_a
        |=> at_bottom && compare_a_flag_r)
        else $error("CLEAR_ON_COMPARE_MODE match did not clear and flag");
    a_ctc_miss: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && waveform_mode_field == TMRCNT_WGM_CTC && !match_a && at_max
        |=> at_bottom && overflow_flag_r)
        else $error("CLEAR_ON_COMPARE_MODE did not wrap past max");
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        overflow_flag_r && !ovf_ack && !wr_hit(req, OFF_FLAGS) |=> overflow_flag_r)
        else $error("Overflow flag cleared by counter");
    a_read_count: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd && req.addr == OFF_COUNT |=> rdata == $past(count_value_r))
        else $error("Count read returned wrong value");

    // Clock source checks, and the CLEAR_ON_COMPARE_MODE count below top
    a_sync_every: assert property (@(posedge sys_clk) disable iff (rst)
        !async_clock_select_r && clock_select_field == 3'h1 |-> timer_clock)
        else $error("Direct clock select missed a tick");
    a_async_gate: assert property (@(posedge sys_clk) disable iff (rst)
        async_clock_select_r && !src_tick |-> !timer_clock)
        else $error("Tick without an oscillator edge");
    a_ctc_count_up: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && waveform_mode_field == TMRCNT_WGM_CTC && !match_a
        |=> count_value_r == $past(count_value_r) + 8'h01)
        else $error("CLEAR_ON_COMPARE_MODE mode did not increment below top");

    // Flag checks
    a_ovf_at_max: assert property (@(posedge sys_clk) disable iff (rst)
        !overflow_flag_r && !(timer_clock && !count_wr && at_max) |=> !overflow_flag_r)
        else $error("Overflow flag set away from max");
    a_ovf_ack_clr: assert property (@(posedge sys_clk) disable iff (rst)
        overflow_flag_r && ovf_ack && !(timer_clock && !count_wr && at_max) |=> !overflow_flag_r)
        else $error("Serviced overflow flag did not clear");
    a_ovf_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
        ovf_ack && timer_clock && !count_wr && at_max && waveform_mode_field == TMRCNT_WGM_NORMAL
        |=> overflow_flag_r)
        else $error("Overflow set lost to a clear");
    a_cmpa_at_match: assert property (@(posedge sys_clk) disable iff (rst)
        !compare_a_flag_r && !(timer_clock && !count_wr && match_a) |=> !compare_a_flag_r)
        else $error("Compare A flag set without a match");
    a_cmpa_ack_clr: assert property (@(posedge sys_clk) disable iff (rst)
        compare_a_flag_r && cmpa_ack && !(timer_clock && !count_wr && match_a) |=> !compare_a_flag_r)
        else $error("Serviced compare A flag did not clear");
    a_cmpb_flag: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && match_b |=> compare_b_flag_r)
        else $error("Compare B match did not flag");
    a_cmpb_ack_clr: assert property (@(posedge sys_clk) disable iff (rst)
        compare_b_flag_r && cmpb_ack && !(timer_clock && !count_wr && match_b) |=> !compare_b_flag_r)
        else $error("Serviced compare B flag did not clear");

    // Output pin checks
    a_toggle_out: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && match_a && !pwm_mode && com_a == 2'h1 |=> cmp_a_r != $past(cmp_a_r))
        else $error("Compare A output did not toggle");
    a_set_out: assert property (@(posedge sys_clk) disable iff (rst)
        timer_clock && !count_wr && match_b && !pwm_mode && com_b == 2'h3 |=> cmp_b_r)
        else $error("Compare B output was not set");
endmodule : tmrcnt_core

// file: verilog/tmrcnt_pkg.sv
// Package for the 8-bit timer counter unit: register map, fields, modes
package tmrcnt_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 4;

    // Register offsets
    localparam logic [3:0] OFF_CTRL_A = 4'h0;
    localparam logic [3:0] OFF_CTRL_B = 4'h1;
    localparam logic [3:0] OFF_COUNT = 4'h2;
    localparam logic [3:0] OFF_CMP_A = 4'h3;
    localparam logic [3:0] OFF_CMP_B = 4'h4;
    localparam logic [3:0] OFF_FLAGS = 4'h5;
    localparam logic [3:0] OFF_ASYNC = 4'h6;

    // Field positions
    localparam int unsigned CTRLA_WGM0_POS = 0;
    localparam int unsigned CTRLA_WGM1_POS = 1;
    localparam int unsigned CTRLA_COMB_POS = 4;
    localparam int unsigned CTRLA_COMA_POS = 6;
    localparam int unsigned CTRLB_CS_POS = 0;
    localparam int unsigned CTRLB_WGM2_POS = 3;
    localparam int unsigned FLAG_OVF_POS = 0;
    localparam int unsigned FLAG_CMPA_POS = 1;
    localparam int unsigned FLAG_CMPB_POS = 2;
    localparam int unsigned ASYNC_SEL_POS = 5;

    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CMP = 8'h00;

    // Count landmarks
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [2:0] CS_STOPPED = 3'h0;

    // Waveform modes
    typedef enum logic [2:0] {
        TMRCNT_WGM_NORMAL = 3'h0,
        TMRCNT_WGM_PC_FF = 3'h1,
        TMRCNT_WGM_CTC = 3'h2,
        TMRCNT_WGM_FAST_FF = 3'h3,
        TMRCNT_WGM_RSVD4 = 3'h4,
        TMRCNT_WGM_PC_CMP = 3'h5,
        TMRCNT_WGM_RSVD6 = 3'h6,
        TMRCNT_WGM_FAST_CMP = 3'h7
    } tmrcnt_wgm_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } tmrcnt_req_t;

    // Compare output pins
    typedef struct packed {
        logic cmp_a;
        logic cmp_b;
    } tmrcnt_cmp_out_t;
endpackage : tmrcnt_pkg

// file: test/tmrcnt_tb.sv
// Self-checking testbench for the 8-bit timer counter core
`timescale 1ns/100ps
module tb import tmrcnt_pkg::*;;
    logic sys_clk;
    logic rst;
    tmrcnt_req_t req;
    logic [7:0] rdata;
    logic osc_pin_in;
    logic osc_pin_out;
    logic ovf_ack;
    logic cmpa_ack;
    logic cmpb_ack;
    logic ovf_irq;
    logic cmpa_irq;
    logic cmpb_irq;
    tmrcnt_cmp_out_t cmp_out;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [7:0] got [3];
    logic ovf_s [3];
    logic cmpa_s [3];
    logic coa_s [3];
    logic [7:0] v;

    tmrcnt_core tmrcnt_core_inst (
        .sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
        .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
        .ovf_ack(ovf_ack), .cmpa_ack(cmpa_ack), .cmpb_ack(cmpb_ack),
        .ovf_irq(ovf_irq), .cmpa_irq(cmpa_irq), .cmpb_irq(cmpb_irq), .cmp_out(cmp_out)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task results;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= {1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        req <= 14'h0000;
    endtask : wr

    task rd(input logic [3:0] a);
        @(posedge sys_clk);
        req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        req <= 14'h0000;
        #1;
        v = rdata;
    endtask : rd

    // Park the count away from any match, clear flags, then write start and
    // read the count back to back three times while the tick runs each cycle
    task run3(input logic [7:0] start);
        wr(OFF_COUNT, 8'h80);
        wr(OFF_FLAGS, 8'h07);
        @(posedge sys_clk);
        req <= {1'b1, 1'b0, OFF_COUNT, start};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            req <= (i < 3) ? {1'b0, 1'b1, OFF_COUNT, 8'h00} : 14'h0000;
            #1;
            if (i > 0) begin
                got[i-1] = rdata;
                ovf_s[i-1] = ovf_irq;
                cmpa_s[i-1] = cmpa_irq;
                coa_s[i-1] = cmp_out.cmp_a;
            end
        end
    endtask : run3

    task t_reset;
        rd(OFF_COUNT);
        check(v, 8'h00);
        rd(OFF_CMP_A);
        check(v, 8'h00);
        rd(OFF_CTRL_A);
        check(v, 8'h00);
        rd(4'h7);
        check(v, 8'h00);
    endtask : t_reset

    task t_ctrl;
        wr(OFF_CTRL_B, 8'hff);
        rd(OFF_CTRL_B);
        check(v, 8'h0f);
        wr(OFF_CTRL_B, 8'h00);
        wr(OFF_CTRL_A, 8'h03);
        rd(OFF_CTRL_A);
        check(v, 8'h03);
        wr(OFF_CTRL_A, 8'h00);
    endtask : t_ctrl

    task t_stop;
        wr(OFF_FLAGS, 8'h07);
        wr(OFF_COUNT, 8'h33);
        repeat (8) @(posedge sys_clk);
        rd(OFF_COUNT);
        check(v, 8'h33);
        check({7'h0, ovf_irq}, 8'h00);
    endtask : t_stop

    task t_normal;
        // Output mode bits set must leave the sequence alone
        wr(OFF_CTRL_A, 8'hc0);
        wr(OFF_CTRL_B, 8'h01);
        run3(8'hfe);
        check(got[0], 8'hfe);
        check(got[1], 8'hff);
        check(got[2], 8'h00);
        check({7'h0, ovf_s[0]}, 8'h00);
        check({7'h0, ovf_s[1]}, 8'h01);
        repeat (20) @(posedge sys_clk);
        #1;
        check({7'h0, ovf_irq}, 8'h01);
        @(posedge sys_clk);
        ovf_ack <= 1'b1;
        @(posedge sys_clk);
        ovf_ack <= 1'b0;
        #1;
        check({7'h0, ovf_irq}, 8'h00);
    endtask : t_normal

    task t_ctc;
        // Mode 2 with compare A toggling its output on match
        wr(OFF_CTRL_A, 8'h42);
        wr(OFF_CMP_A, 8'h11);
        run3(8'h10);
        check(got[0], 8'h10);
        check(got[1], 8'h11);
        check(got[2], 8'h00);
        check({7'h0, cmpa_s[0]}, 8'h00);
        check({7'h0, cmpa_s[1]}, 8'h01);
        check({7'h0, coa_s[2] ^ coa_s[0]}, 8'h01);
        @(posedge sys_clk);
        cmpa_ack <= 1'b1;
        @(posedge sys_clk);
        cmpa_ack <= 1'b0;
        #1;
        check({7'h0, cmpa_irq}, 8'h00);
        wr(OFF_CMP_A, 8'h05);
        run3(8'hfe);
        check(got[1], 8'hff);
        check(got[2], 8'h00);
        check({7'h0, ovf_s[1]}, 8'h01);
        check({7'h0, cmpa_s[0] | cmpa_s[1] | cmpa_s[2]}, 8'h00);
    endtask : t_ctc

    task t_async;
        wr(OFF_CTRL_B, 8'h00);
        wr(OFF_CTRL_A, 8'h00);
        wr(OFF_COUNT, 8'h00);
        wr(OFF_ASYNC, 8'h20);
        wr(OFF_CTRL_B, 8'h01);
        repeat (12) @(posedge sys_clk);
        rd(OFF_COUNT);
        check(v, 8'h00);
        // Slow oscillator edges, each wide enough for the synchroniser
        repeat (3) begin
            @(posedge sys_clk);
            osc_pin_in <= 1'b1;
            repeat (6) @(posedge sys_clk);
            osc_pin_in <= 1'b0;
            repeat (6) @(posedge sys_clk);
        end
        repeat (6) @(posedge sys_clk);
        rd(OFF_COUNT);
        check(v, 8'h03);
        wr(OFF_ASYNC, 8'h00);
        wr(OFF_CTRL_B, 8'h00);
    endtask : t_async

    // Compare B in set mode, its service clear, and the divide-by-eight tap
    task t_cmpb;
        wr(OFF_CTRL_A, 8'h30);
        wr(OFF_CMP_B, 8'h40);
        wr(OFF_COUNT, 8'h3c);
        wr(OFF_FLAGS, 8'h07);
        #1;
        check({7'h0, cmpb_irq}, 8'h00);
        wr(OFF_CTRL_B, 8'h01);
        repeat (8) @(posedge sys_clk);
        #1;
        check({7'h0, cmpb_irq}, 8'h01);
        check({7'h0, cmp_out.cmp_b}, 8'h01);
        check({7'h0, osc_pin_out}, 8'h00);
        @(posedge sys_clk);
        cmpb_ack <= 1'b1;
        @(posedge sys_clk);
        cmpb_ack <= 1'b0;
        #1;
        check({7'h0, cmpb_irq}, 8'h00);
        // Two reads eight cycles apart see exactly one tap tick
        wr(OFF_CTRL_B, 8'h02);
        rd(OFF_COUNT);
        got[0] = v;
        repeat (6) @(posedge sys_clk);
        rd(OFF_COUNT);
        check(v - got[0], 8'h01);
        wr(OFF_CTRL_B, 8'h00);
    endtask : t_cmpb

    initial begin
        rst = 1'b1;
        req = 14'h0000;
        osc_pin_in = 1'b0;
        ovf_ack = 1'b0;
        cmpa_ack = 1'b0;
        cmpb_ack = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_ctrl();
        t_stop();
        t_normal();
        t_ctc();
        t_async();
        t_cmpb();
        results();
    end
endmodule : tb
